//--- rtl/tsc_defs.vh
// Constants shared by the temperature sensor settings and measurement control.
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH
// ==========================================================================
// Reset values
`define TSC_CFG_RST 8'h00
`define TSC_TEMP_RST 12'h000
`define TSC_PTR_RST 2'h0
`define TSC_LOW_BYTE 8'h00
// ==========================================================================
// Pointer values
`define TSC_PTR_TEMP 2'h0
`define TSC_PTR_CFG 2'h1
`define TSC_PTR_MAX 8'h03
// ==========================================================================
// Bus address and byte framing
`define TSC_DEV_PREFIX 4'h9
`define TSC_BYTE_DONE 4'h8
`define TSC_CNT_ZERO 4'h0
`define TSC_CNT_ONE 4'h1
// ==========================================================================
// Upper settings byte field positions
`define TSC_B_OS 7
`define TSC_B_RES_HI 6
`define TSC_B_RES_LO 5
`define TSC_B_FQ_HI 4
`define TSC_B_FQ_LO 3
`define TSC_B_POL 2
`define TSC_B_MODE 1
`define TSC_B_SD 0
// ==========================================================================
// Conversion times and clock rate
`define TSC_CLK_KHZ 25000
`define TSC_CONV9_MS 25
`define TSC_CONV10_MS 50
`define TSC_CONV11_MS 100
`define TSC_CONV12_MS 200
// ==========================================================================
// Resolution masks and fault queue depths
`define TSC_MASK9 12'hff8
`define TSC_MASK10 12'hffc
`define TSC_MASK11 12'hffe
`define TSC_MASK12 12'hfff
`define TSC_FQ1 3'h1
`define TSC_FQ2 3'h2
`define TSC_FQ4 3'h4
`define TSC_FQ6 3'h6
`define TSC_FCNT_ZERO 3'h0
`define TSC_FCNT_ONE 3'h1
`endif

//--- rtl/tsc_sync.v
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`include "tsc_defs.vh"
module tsc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] out_q;
  // ==========================================================================
  // Chain; the output follows only when stages two and three agree.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      out_q <= RST;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end
  assign q_o = out_q;
endmodule

//--- rtl/tsc_ctrl.v
// Settings register, two-wire slave and measurement control of the sensor.
`timescale 1ns/100ps
`include "tsc_defs.vh"
module tsc_ctrl #(
  parameter CW = 24,
  parameter [CW-1:0] CONV9_CYC = `TSC_CONV9_MS * `TSC_CLK_KHZ,
  parameter [CW-1:0] CONV10_CYC = `TSC_CONV10_MS * `TSC_CLK_KHZ,
  parameter [CW-1:0] CONV11_CYC = `TSC_CONV11_MS * `TSC_CLK_KHZ,
  parameter [CW-1:0] CONV12_CYC = `TSC_CONV12_MS * `TSC_CLK_KHZ
) (
  input wire clk_i,
  input wire rstn_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire [2:0] strap_address_pins_i,
  input wire [11:0] adc_result_i,
  input wire adc_fault_i,
  output wire conv_busy_o,
  output wire [1:0] resolution_select_o,
  output wire alarm_o
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_AACK = 9'h004;
  localparam [8:0] S_PTR = 9'h008;
  localparam [8:0] S_WDAT = 9'h010;
  localparam [8:0] S_WACK = 9'h020;
  localparam [8:0] S_RDAT = 9'h040;
  localparam [8:0] S_RACK = 9'h080;
  localparam [8:0] S_WAIT = 9'h100;
  localparam [CW-1:0] TMR_ONE = {{(CW-1){1'b0}}, 1'b1};

  // ==========================================================================
  // Helper functions
  function [CW-1:0] conv_len;
    input [1:0] r;
    begin
      case (r)
        2'h0: conv_len = CONV9_CYC;
        2'h1: conv_len = CONV10_CYC;
        2'h2: conv_len = CONV11_CYC;
        default: conv_len = CONV12_CYC;
      endcase
    end
  endfunction

  function [11:0] res_mask;
    input [1:0] r;
    begin
      case (r)
        2'h0: res_mask = `TSC_MASK9;
        2'h1: res_mask = `TSC_MASK10;
        2'h2: res_mask = `TSC_MASK11;
        default: res_mask = `TSC_MASK12;
      endcase
    end
  endfunction

  function [2:0] fq_depth;
    input [1:0] f;
    begin
      case (f)
        2'h0: fq_depth = `TSC_FQ1;
        2'h1: fq_depth = `TSC_FQ2;
        2'h2: fq_depth = `TSC_FQ4;
        default: fq_depth = `TSC_FQ6;
      endcase
    end
  endfunction

  // ==========================================================================
  // Declarations
  wire scl_s;
  wire sda_s;
  wire [2:0] strap_s;
  reg scl_prev_q;
  reg sda_prev_q;
  reg [8:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] sr_q;
  reg [7:0] tx_q;
  reg oe_q;
  reg [1:0] ptr_q;
  reg first_q;
  reg hi_q;
  reg mack_q;
  reg [7:0] cfg_q;
  reg os_q;
  reg os_run_q;
  reg conv_q;
  reg [CW-1:0] tmr_q;
  reg [1:0] res_run_q;
  reg [11:0] temp_q;
  reg [11:0] new_q;
  reg upd_q;
  reg [2:0] fcnt_q;
  reg int_q;
  reg alarm_q;
  reg [15:0] rd_word;
  wire conv_end;

  // ==========================================================================
  // Pin synchronisers
  tsc_sync #(.W(1), .RST(1'b1)) u_scl (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(scl_i),
    .q_o(scl_s)
  );

  tsc_sync #(.W(1), .RST(1'b1)) u_sda (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );

  tsc_sync #(.W(3), .RST(3'h0)) u_strap (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(strap_address_pins_i),
    .q_o(strap_s)
  );

  // ==========================================================================
  // Bus events
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire byte_end = scl_fall & (cnt_q == `TSC_BYTE_DONE);
  wire addr_hit = (sr_q[7:1] == {`TSC_DEV_PREFIX, strap_s});
  wire rd_req = byte_end & (state_q == S_ADDR) & addr_hit & sr_q[0];
  wire ptr_ok = (sr_q <= `TSC_PTR_MAX);
  wire cfg_wr = byte_end & (state_q == S_WDAT) & (ptr_q == `TSC_PTR_CFG) & first_q;
  wire temp_rd = ((state_q == S_RDAT) | (state_q == S_RACK)) & (ptr_q == `TSC_PTR_TEMP);

  // Read data; the single-shot bit and the reserved low byte read as zero.
  always @* begin
    case (ptr_q)
      `TSC_PTR_TEMP: rd_word = {temp_q, 4'h0};
      `TSC_PTR_CFG: rd_word = {1'b0, cfg_q[6:0], `TSC_LOW_BYTE};
      default: rd_word = {8'h00, `TSC_LOW_BYTE};
    endcase
  end

  // ==========================================================================
  // Two-wire slave state machine
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      state_q <= S_IDLE;
      cnt_q <= `TSC_CNT_ZERO;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      ptr_q <= `TSC_PTR_RST;
      first_q <= 1'b0;
      hi_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      if (bus_start) begin
        // A partial byte is simply dropped here.
        state_q <= S_ADDR;
        cnt_q <= `TSC_CNT_ZERO;
        oe_q <= 1'b0;
      end else if (bus_stop) begin
        state_q <= S_IDLE;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          S_ADDR, S_PTR, S_WDAT: begin
            sr_q <= {sr_q[6:0], sda_s};
            cnt_q <= cnt_q + `TSC_CNT_ONE;
          end
          S_RDAT: begin
            cnt_q <= cnt_q + `TSC_CNT_ONE;
          end
          S_RACK: begin
            mack_q <= ~sda_s;
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            if (cnt_q == `TSC_BYTE_DONE) begin
              if (addr_hit) begin
                state_q <= S_AACK;
                oe_q <= 1'b1;
              end else begin
                state_q <= S_WAIT;
              end
            end
          end
          S_AACK: begin
            cnt_q <= `TSC_CNT_ZERO;
            first_q <= 1'b1;
            if (sr_q[0]) begin
              // Upper byte goes out first.
              state_q <= S_RDAT;
              tx_q <= rd_word[15:8];
              hi_q <= 1'b1;
              oe_q <= ~rd_word[15];
            end else begin
              state_q <= S_PTR;
              oe_q <= 1'b0;
            end
          end
          S_PTR: begin
            if (cnt_q == `TSC_BYTE_DONE) begin
              if (ptr_ok) begin
                ptr_q <= sr_q[1:0];
                state_q <= S_WACK;
                oe_q <= 1'b1;
              end else begin
                state_q <= S_WAIT;
              end
            end
          end
          S_WDAT: begin
            if (cnt_q == `TSC_BYTE_DONE) begin
              first_q <= 1'b0;
              if (ptr_q == `TSC_PTR_TEMP) begin
                state_q <= S_WAIT;
              end else begin
                state_q <= S_WACK;
                oe_q <= 1'b1;
              end
            end
          end
          S_WACK: begin
            state_q <= S_WDAT;
            cnt_q <= `TSC_CNT_ZERO;
            oe_q <= 1'b0;
          end
          S_RDAT: begin
            if (cnt_q == `TSC_BYTE_DONE) begin
              state_q <= S_RACK;
              oe_q <= 1'b0;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              oe_q <= ~tx_q[6];
            end
          end
          S_RACK: begin
            cnt_q <= `TSC_CNT_ZERO;
            if (mack_q) begin
              state_q <= S_RDAT;
              hi_q <= ~hi_q;
              tx_q <= hi_q ? rd_word[7:0] : rd_word[15:8];
              oe_q <= hi_q ? ~rd_word[7] : ~rd_word[15];
            end else begin
              state_q <= S_WAIT;
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Settings register and single-shot request
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= `TSC_CFG_RST;
      os_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cfg_q <= {1'b0, sr_q[6:0]};
      end
      if (cfg_wr & sr_q[`TSC_B_OS] & sr_q[`TSC_B_SD] & cfg_q[`TSC_B_SD]) begin
        os_q <= 1'b1;
      end else if (conv_end & os_run_q) begin
        os_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Conversion timing
  assign conv_end = conv_q & (tmr_q == TMR_ONE);
  wire conv_start = ~conv_q & (~cfg_q[`TSC_B_SD] | os_q);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_q <= 1'b0;
      os_run_q <= 1'b0;
      tmr_q <= {CW{1'b0}};
      res_run_q <= 2'h0;
    end else begin
      if (conv_start) begin
        // The resolution is latched for the run so a change to it waits for the end; resolution_select_o and the alarm settings follow cfg_q at once.
        conv_q <= 1'b1;
        os_run_q <= cfg_q[`TSC_B_SD];
        res_run_q <= cfg_q[`TSC_B_RES_HI:`TSC_B_RES_LO];
        tmr_q <= conv_len(cfg_q[`TSC_B_RES_HI:`TSC_B_RES_LO]);
      end else if (conv_end) begin
        conv_q <= 1'b0;
        os_run_q <= 1'b0;
      end else if (conv_q) begin
        tmr_q <= tmr_q - TMR_ONE;
      end
    end
  end

  // ==========================================================================
  // Temperature result, held back while it is being read
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      temp_q <= `TSC_TEMP_RST;
      new_q <= `TSC_TEMP_RST;
      upd_q <= 1'b0;
    end else begin
      if (conv_end) begin
        new_q <= adc_result_i & res_mask(res_run_q);
        upd_q <= 1'b1;
      end else if (upd_q & ~temp_rd) begin
        temp_q <= new_q;
        upd_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Fault queue and alarm output
  wire [2:0] depth = fq_depth(cfg_q[`TSC_B_FQ_HI:`TSC_B_FQ_LO]);
  wire [2:0] fcnt_n = (fcnt_q == `TSC_FQ6) ? fcnt_q : fcnt_q + `TSC_FCNT_ONE;
  wire alarm_act = cfg_q[`TSC_B_MODE] ? int_q : (fcnt_q >= depth);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fcnt_q <= `TSC_FCNT_ZERO;
      int_q <= 1'b0;
      alarm_q <= 1'b1;
    end else begin
      if (conv_end) begin
        fcnt_q <= adc_fault_i ? fcnt_n : `TSC_FCNT_ZERO;
      end
      if (conv_end & adc_fault_i & (fcnt_n == depth) & (fcnt_q != depth)) begin
        int_q <= 1'b1;
      end else if (rd_req) begin
        int_q <= 1'b0;
      end
      alarm_q <= cfg_q[`TSC_B_POL] ? alarm_act : ~alarm_act;
    end
  end

  // ==========================================================================
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign conv_busy_o = conv_q;
  assign resolution_select_o = cfg_q[`TSC_B_RES_HI:`TSC_B_RES_LO];
  assign alarm_o = alarm_q;
endmodule

//--- bench/tsc_ctrl_assertions.sv
// Checker on the ports of the sensor settings and measurement control.
`timescale 1ns/100ps
module tsc_ctrl_chk #(
  parameter CW = 24,
  parameter [CW-1:0] CONV9_CYC = 1,
  parameter [CW-1:0] CONV10_CYC = 1,
  parameter [CW-1:0] CONV11_CYC = 1,
  parameter [CW-1:0] CONV12_CYC = 1
) (
  input wire clk_i,
  input wire rstn_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire conv_busy_o,
  input wire [1:0] resolution_select_o,
  input wire alarm_o
);
  // ==========================================================
  // Conversion length bookkeeping
  reg [CW-1:0] cnt_q;
  reg [1:0] res_q;
  wire [CW-1:0] len = res_q[1] ? (res_q[0] ? CONV12_CYC : CONV11_CYC) :
    (res_q[0] ? CONV10_CYC : CONV9_CYC);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      res_q <= 2'h0;
    end else begin
      cnt_q <= conv_busy_o ? cnt_q + 1'b1 : '0;
      if (!conv_busy_o) res_q <= resolution_select_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // Properties
  property p_sdo;
    sda_oe_o |-> sda_o == 1'b0;
  endproperty
  a_sdo: assert property (p_sdo) else $error("sda driven high");
  property p_oe_rst;
    $rose(rstn_i) |-> !sda_oe_o && !conv_busy_o;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("reset outputs");
  property p_res_rst;
    $rose(rstn_i) |-> resolution_select_o == 2'h0 && alarm_o;
  endproperty
  a_res_rst: assert property (p_res_rst) else $error("reset settings");
  property p_start;
    $rose(rstn_i) |-> ##[1:3] conv_busy_o;
  endproperty
  a_start: assert property (p_start) else $error("no first conversion");
  property p_len;
    $fell(conv_busy_o) |-> cnt_q + 1'b1 >= len && cnt_q <= len + 1'b1;
  endproperty
  a_len: assert property (p_len) else $error("conversion length");
  property p_min;
    $rose(conv_busy_o) |-> conv_busy_o [*8];
  endproperty
  a_min: assert property (p_min) else $error("conversion too short");
  property p_ack_res;
    $changed(resolution_select_o) |-> ##[0:3] sda_oe_o;
  endproperty
  a_ack_res: assert property (p_ack_res) else $error("settings without ack");
  property p_oe_len;
    $rose(sda_oe_o) |-> sda_oe_o [*2];
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("short drive");
  c_conv: cover property ($rose(conv_busy_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_alarm: cover property ($rose(alarm_o));
endmodule
bind tsc_ctrl tsc_ctrl_chk #(.CW(CW), .CONV9_CYC(CONV9_CYC), .CONV10_CYC(CONV10_CYC),
  .CONV11_CYC(CONV11_CYC), .CONV12_CYC(CONV12_CYC)) chk_u (.clk_i(clk_i),
  .rstn_i(rstn_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_busy_o(conv_busy_o),
  .resolution_select_o(resolution_select_o), .alarm_o(alarm_o));

//--- bench/tsc_mst.sv
// Two-wire bus master model that drives the sensor's bus pins.
`timescale 1ns/100ps
module tsc_mst (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data changes five cycles after the clock falls, in step with the slave's own
  // data and release, so no edge of the data line is ever seen with the clock high.
  task automatic bit_t(input logic b, output logic r);
    sda_low_o <= !b;
    tick(1);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    scl_o <= 1'b0;
    tick(5);
  endtask
  task automatic start();
    sda_low_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(6);
    sda_low_o <= 1'b1;
    tick(6);
    scl_o <= 1'b0;
    tick(5);
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(6);
    sda_low_o <= 1'b0;
    tick(8);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_t(d[i], r);
    bit_t(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_t(1'b1, r);
      d[i] = r;
    end
    bit_t(last, r);
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench of the sensor settings and measurement control.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [11:0] adc = 12'h000;
  logic fault = 1'b0;
  logic scl;
  logic sda_low;
  logic a;
  logic [7:0] cfg_m = 8'h00;
  logic [15:0] w;
  wire sda_o;
  wire sda_oe;
  wire busy;
  wire [1:0] res;
  wire alarm;
  wire sda = (sda_oe ? sda_o : 1'b1) & !sda_low;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  tsc_ctrl #(.CW(24), .CONV9_CYC(24'h32), .CONV10_CYC(24'h64), .CONV11_CYC(24'hc8),
    .CONV12_CYC(24'h190)) dut_u (.clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .strap_address_pins_i(strap), .adc_result_i(adc),
    .adc_fault_i(fault), .conv_busy_o(busy), .resolution_select_o(res), .alarm_o(alarm));
  tsc_mst mst_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("Compared %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
    logic k;
    mst_u.start();
    mst_u.wbyte({4'h9, strap, 1'b0}, k);
    chk("addr ack", 1, k);
    mst_u.wbyte(p, k);
    chk("ptr ack", 1, k);
    repeat (n) begin
      mst_u.wbyte(d, k);
      d = ~d;
    end
    mst_u.stop();
  endtask
  task automatic rd(output logic [15:0] v);
    logic k;
    mst_u.start();
    mst_u.wbyte({4'h9, strap, 1'b1}, k);
    chk("read ack", 1, k);
    mst_u.rbyte(1'b0, v[15:8]);
    mst_u.rbyte(1'b1, v[7:0]);
    mst_u.stop();
  endtask
  task automatic wfall();
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 900) begin
      @(posedge clk);
      k++;
    end
    while (busy !== 1'b0 && k < 900) begin
      @(posedge clk);
      k++;
    end
    if (k >= 900) chk("conversion end", 0, 1);
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(44754));
    strap <= $urandom;
    adc <= $urandom;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    wfall();
    rd(w);
    chk("temp default ptr", {adc & 12'hff8, 4'h0}, w);
    wr(8'h01, 8'h00, 0);
    rd(w);
    chk("cfg reset", 16'h0000, w);
    cfg_m = $urandom & 8'h7e;
    wr(8'h01, cfg_m, 2);
    rd(w);
    chk("cfg first byte", {cfg_m, 8'h00}, w);
    mst_u.start();
    mst_u.wbyte({4'h9, strap, 1'b0}, a);
    mst_u.wbyte(8'h01, a);
    repeat (4) mst_u.bit_t(1'b0, a);
    mst_u.stop();
    rd(w);
    chk("cfg partial", {cfg_m, 8'h00}, w);
    wr(8'h01, 8'h80, 1);
    rd(w);
    chk("single shot ignored", 16'h0000, w);
    for (int r = 0; r < 4; r++) begin
      cfg_m = {1'b0, r[1:0], 5'h00};
      wr(8'h01, cfg_m, 1);
      chk("resolution out", r[1:0], res);
      wfall();
      adc <= $urandom;
      wfall();
      wr(8'h00, 8'h00, 0);
      rd(w);
      chk("temp masked", {adc & (12'hfff << (3 - r)), 4'h0}, w);
    end
    wr(8'h01, 8'h0c, 1);
    wfall();
    fault <= 1'b1;
    wfall();
    chk("alarm one fault", 0, alarm);
    wfall();
    chk("alarm two faults", 1, alarm);
    fault <= 1'b0;
    wfall();
    chk("alarm cleared", 0, alarm);
    wr(8'h01, 8'h01, 1);
    repeat (200) @(posedge clk);
    chk("halted", 0, busy);
    wr(8'h01, 8'h81, 1);
    wfall();
    repeat (150) @(posedge clk);
    chk("single shot done", 0, busy);
    rd(w);
    chk("single shot clear", 16'h0100, w);
    wr(8'h01, 8'h00, 1);
    repeat (20) @(posedge clk);
    chk("resumed", 1, busy);
    stop_test();
  end
endmodule
